// ---- design/gas_address_select.sv ----
`timescale 1ns/1ps
module gas_address_select
    import gas_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [4:0] ADDR_SWITCH,
    input wire logic TALK_ONLY_SWITCH,
    input wire logic LISTEN_ONLY_SWITCH,
    input wire logic PANEL_ADDRESS_ENTRY_PERMIT,
    input wire logic SHOW_BUS_ADDRESS_KEY,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [4:0] BUS_ADDRESS,
    output logic TALK_ONLY,
    output logic LISTEN_ONLY,
    output logic [7:0] TALK_CHAR,
    output logic [7:0] LISTEN_CHAR,
    output logic [7:0] NUMERIC_READOUT,
    output logic READOUT_ACTIVE
);
    // Register decode uses address bits 7:2, so narrower buses cannot be served
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : gen_addr_w_check
        $error("ADDR_W out of range");
    end

    logic [4:0] sw_addr_reg;
    logic sw_talk_reg;
    logic sw_listen_reg;
    logic sw_permit_reg;
    logic [4:0] panel_addr_reg;
    logic panel_src_reg;
    logic [4:0] keyed_addr_reg;
    logic reject_reg;
    gas_entry_t entry_reg;
    logic [4:0] eff_addr;
    logic [5:0] report_addr;
    logic [7:0] readout_next;

    // Switches sampled every cycle; outputs settle on the second edge after reset release
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            sw_addr_reg <= GAS_ADDR_FACTORY;
            sw_talk_reg <= 1'b0;
            sw_listen_reg <= 1'b0;
            sw_permit_reg <= 1'b0;
        end
        else
        begin
            sw_addr_reg <= ADDR_SWITCH;
            sw_talk_reg <= TALK_ONLY_SWITCH;
            sw_listen_reg <= LISTEN_ONLY_SWITCH;
            sw_permit_reg <= PANEL_ADDRESS_ENTRY_PERMIT;
        end
    end

    // AXI4-Lite write path
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    assign S_AXI_AWREADY = !aw_hold_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_hold_reg && !S_AXI_BVALID;
    assign wr_fire = aw_hold_reg && w_hold_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            else if (wr_fire)
                aw_hold_reg <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            else if (wr_fire)
                w_hold_reg <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_panel;
    logic wr_ok;
    logic aw_in_map;
    // High address bits must be clear, otherwise the writable registers would alias
    assign aw_in_map = (aw_addr_reg >> 8) == '0;
    assign wr_ctrl = wr_fire && aw_in_map && aw_addr_reg[7:2] == GAS_OFF_CTRL[7:2] && w_strb_reg[0];
    assign wr_panel = wr_fire && aw_in_map && aw_addr_reg[7:2] == GAS_OFF_PANEL[7:2] && w_strb_reg[0];
    assign wr_ok = aw_in_map && (aw_addr_reg[7:2] == GAS_OFF_CTRL[7:2] || aw_addr_reg[7:2] == GAS_OFF_PANEL[7:2]);

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= GAS_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? GAS_RESP_OKAY : GAS_RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end

    // Panel entry: key value, then store, then local commits it
    logic store_keypress;
    logic local_keypress;
    logic entry_drop;
    assign store_keypress = wr_ctrl && w_data_reg[GAS_CTRL_STORE_BIT];
    assign local_keypress = wr_ctrl && w_data_reg[GAS_CTRL_LOCAL_BIT];
    assign entry_drop = wr_ctrl && !w_data_reg[GAS_CTRL_ENTRY_BIT];

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            entry_reg <= GAS_ENTRY_IDLE;
            keyed_addr_reg <= '0;
            panel_addr_reg <= GAS_ADDR_FACTORY;
            panel_src_reg <= 1'b0;
            reject_reg <= 1'b0;
        end
        else
        begin
            if (entry_drop)
                panel_src_reg <= 1'b0;
            if (wr_panel)
            begin
                // Value 31 and entries without permit are refused and flagged
                if (!sw_permit_reg || w_data_reg[4:0] > GAS_ADDR_MAX)
                begin
                    reject_reg <= 1'b1;
                    entry_reg <= GAS_ENTRY_IDLE;
                end
                else
                begin
                    reject_reg <= 1'b0;
                    keyed_addr_reg <= w_data_reg[4:0];
                    entry_reg <= GAS_ENTRY_KEYED;
                end
            end
            else
            begin
                case (entry_reg)
                    GAS_ENTRY_IDLE:
                        entry_reg <= GAS_ENTRY_IDLE;
                    GAS_ENTRY_KEYED:
                        if (store_keypress)
                            entry_reg <= GAS_ENTRY_STORED;
                        else if (local_keypress)
                            entry_reg <= GAS_ENTRY_IDLE;
                    GAS_ENTRY_STORED:
                        if (local_keypress)
                        begin
                            entry_reg <= GAS_ENTRY_IDLE;
                            if (sw_permit_reg)
                            begin
                                panel_addr_reg <= keyed_addr_reg;
                                panel_src_reg <= 1'b1;
                            end
                        end
                    default:
                        entry_reg <= GAS_ENTRY_IDLE;
                endcase
            end
            // Withdrawing the permit switch falls back to the switch bank
            if (!sw_permit_reg)
                panel_src_reg <= 1'b0;
        end
    end

    // Switch value 31 is not allowed; treated as the factory address
    always_comb
    begin
        if (panel_src_reg)
            eff_addr = panel_addr_reg;
        else if (sw_addr_reg > GAS_ADDR_MAX)
            eff_addr = GAS_ADDR_FACTORY;
        else
            eff_addr = sw_addr_reg;
        if (sw_talk_reg)
            report_addr = GAS_ADDR_TALK_ONLY;
        else if (sw_listen_reg)
            report_addr = GAS_ADDR_LISTEN_ONLY;
        else
            report_addr = {1'b0, eff_addr};
        // Decimal readout as two BCD digits
        readout_next = {4'(report_addr / 6'd10), 4'(report_addr % 6'd10)};
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            BUS_ADDRESS <= GAS_ADDR_FACTORY;
            TALK_ONLY <= 1'b0;
            LISTEN_ONLY <= 1'b0;
            TALK_CHAR <= GAS_TALK_BASE + 8'(GAS_ADDR_FACTORY);
            LISTEN_CHAR <= GAS_LISTEN_BASE + 8'(GAS_ADDR_FACTORY);
            NUMERIC_READOUT <= 8'h00;
            READOUT_ACTIVE <= 1'b0;
        end
        else
        begin
            BUS_ADDRESS <= eff_addr;
            TALK_ONLY <= sw_talk_reg;
            LISTEN_ONLY <= sw_listen_reg && !sw_talk_reg;
            TALK_CHAR <= GAS_TALK_BASE + 8'(eff_addr);
            LISTEN_CHAR <= GAS_LISTEN_BASE + 8'(eff_addr);
            NUMERIC_READOUT <= SHOW_BUS_ADDRESS_KEY ? readout_next : 8'h00;
            READOUT_ACTIVE <= SHOW_BUS_ADDRESS_KEY;
        end
    end

    // AXI4-Lite read path, one cycle answer
    logic [31:0] rd_data;
    always_comb
    begin
        rd_data = '0;
        case (S_AXI_ARADDR[7:2])
            GAS_OFF_CTRL[7:2]:
                rd_data[GAS_CTRL_ENTRY_BIT] = panel_src_reg;
            GAS_OFF_STATUS[7:2]:
            begin
                rd_data[GAS_ST_ADDR_LSB +: 6] = report_addr;
                rd_data[GAS_ST_TALK_ONLY_BIT] = sw_talk_reg;
                rd_data[GAS_ST_LISTEN_ONLY_BIT] = sw_listen_reg && !sw_talk_reg;
                rd_data[GAS_ST_PANEL_SRC_BIT] = panel_src_reg;
                rd_data[GAS_ST_PERMIT_BIT] = sw_permit_reg;
                rd_data[GAS_ST_REJECT_BIT] = reject_reg;
                rd_data[GAS_ST_PENDING_BIT] = entry_reg != GAS_ENTRY_IDLE;
            end
            GAS_OFF_PANEL[7:2]:
                rd_data[4:0] = panel_addr_reg;
            GAS_OFF_CHARS[7:2]:
            begin
                rd_data[GAS_CH_TALK_LSB +: 8] = TALK_CHAR;
                rd_data[GAS_CH_LISTEN_LSB +: 8] = LISTEN_CHAR;
            end
            default:
                rd_data = '0;
        endcase
    end

    logic rd_ok;
    assign rd_ok = S_AXI_ARADDR[7:2] <= GAS_OFF_CHARS[7:2] && (S_AXI_ARADDR >> 8) == '0;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= GAS_RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_ok ? rd_data : 32'h0000_0000;
            S_AXI_RRESP <= rd_ok ? GAS_RESP_OKAY : GAS_RESP_SLVERR;
        end
        else if (S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
    end
endmodule

// ---- design/gas_pkg.sv ----
package gas_pkg;
    // AXI4-Lite register map (byte addresses)
    localparam logic [7:0] GAS_OFF_CTRL = 8'h00;
    localparam logic [7:0] GAS_OFF_STATUS = 8'h04;
    localparam logic [7:0] GAS_OFF_PANEL = 8'h08;
    localparam logic [7:0] GAS_OFF_CHARS = 8'h0C;
    // Control register fields
    localparam int GAS_CTRL_ENTRY_BIT = 0;
    localparam int GAS_CTRL_STORE_BIT = 1;
    localparam int GAS_CTRL_LOCAL_BIT = 2;
    // Status register fields
    localparam int GAS_ST_ADDR_LSB = 0;
    localparam int GAS_ST_TALK_ONLY_BIT = 8;
    localparam int GAS_ST_LISTEN_ONLY_BIT = 9;
    localparam int GAS_ST_PANEL_SRC_BIT = 10;
    localparam int GAS_ST_PERMIT_BIT = 11;
    localparam int GAS_ST_REJECT_BIT = 12;
    localparam int GAS_ST_PENDING_BIT = 13;
    // Character register fields
    localparam int GAS_CH_TALK_LSB = 0;
    localparam int GAS_CH_LISTEN_LSB = 8;
    // Address values
    localparam logic [4:0] GAS_ADDR_FACTORY = 5'h13;
    localparam logic [4:0] GAS_ADDR_MAX = 5'h1E;
    localparam logic [5:0] GAS_ADDR_TALK_ONLY = 6'h32;
    localparam logic [5:0] GAS_ADDR_LISTEN_ONLY = 6'h28;
    localparam logic [7:0] GAS_TALK_BASE = 8'h40;
    localparam logic [7:0] GAS_LISTEN_BASE = 8'h20;
    localparam logic [1:0] GAS_RESP_OKAY = 2'h0;
    localparam logic [1:0] GAS_RESP_SLVERR = 2'h2;
    typedef enum {GAS_ENTRY_IDLE, GAS_ENTRY_KEYED, GAS_ENTRY_STORED} gas_entry_t;
endpackage

// ---- bench/gas_monitor.sv ----
`timescale 1ns/1ps
module gas_monitor
    import gas_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic TALK_ONLY_SWITCH,
    input wire logic LISTEN_ONLY_SWITCH,
    input wire logic SHOW_BUS_ADDRESS_KEY,
    input wire logic [4:0] BUS_ADDRESS,
    input wire logic TALK_ONLY,
    input wire logic LISTEN_ONLY,
    input wire logic [7:0] TALK_CHAR,
    input wire logic [7:0] LISTEN_CHAR,
    input wire logic [7:0] NUMERIC_READOUT,
    input wire logic READOUT_ACTIVE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    a_talk_char_sum: assert property (TALK_CHAR == GAS_TALK_BASE + {3'h0, BUS_ADDRESS})
        else $error("talk char wrong");
    a_listen_char_sum: assert property (LISTEN_CHAR == GAS_LISTEN_BASE + {3'h0, BUS_ADDRESS})
        else $error("listen char wrong");
    a_addr_not_31: assert property (BUS_ADDRESS != 5'h1F)
        else $error("address 31 used");
    // Two clean edges needed: one to sample the switches, one to update the outputs
    a_talk_only_track: assert property (!$past(SRST) && !$past(SRST, 2) |-> TALK_ONLY == $past(TALK_ONLY_SWITCH, 2))
        else $error("talk-only wrong");
    a_listen_only_track: assert property (!$past(SRST) && !$past(SRST, 2) |->
        LISTEN_ONLY == ($past(LISTEN_ONLY_SWITCH, 2) && !$past(TALK_ONLY_SWITCH, 2)))
        else $error("listen-only wrong");
    a_readout_key: assert property (!$past(SRST) |-> READOUT_ACTIVE == $past(SHOW_BUS_ADDRESS_KEY))
        else $error("readout key lag wrong");
    a_readout_blank: assert property (!READOUT_ACTIVE |-> NUMERIC_READOUT == 8'h00)
        else $error("readout not blank");
    a_readout_talk: assert property (READOUT_ACTIVE && TALK_ONLY && $past(TALK_ONLY) |-> NUMERIC_READOUT == 8'h50)
        else $error("talk-only readout wrong");
endmodule
bind gas_address_select gas_monitor gas_monitor_i (.*);

// ---- bench/gas_switch_model.sv ----
`timescale 1ns/1ps
module gas_switch_model
(
    input wire logic [8:0] setting,
    output logic [4:0] addr_switch,
    output logic talk_only_switch,
    output logic listen_only_switch,
    output logic entry_permit,
    output logic show_key
);
    // Contacts are clean here; bounce would need a settle time the block does not have
    assign addr_switch = setting[4:0];
    assign talk_only_switch = setting[5];
    assign listen_only_switch = setting[6];
    assign entry_permit = setting[7];
    assign show_key = setting[8];
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb
    import gas_pkg::*;
;
    logic CLK_SYS = 1'b0;
    logic SRST = 1'b1;
    logic [8:0] sw = 9'h013;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdv;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TALK_ONLY, LISTEN_ONLY;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [4:0] ADDR_SWITCH, BUS_ADDRESS;
    logic TALK_ONLY_SWITCH, LISTEN_ONLY_SWITCH, PANEL_ADDRESS_ENTRY_PERMIT, SHOW_BUS_ADDRESS_KEY, READOUT_ACTIVE;
    logic [7:0] TALK_CHAR, LISTEN_CHAR, NUMERIC_READOUT;
    int failures = 0, tests_run = 0, cyc = 0, i, e;
    gas_address_select gas_address_select_i (.*);
    gas_switch_model gas_switch_model_i (.setting(sw), .addr_switch(ADDR_SWITCH), .talk_only_switch(TALK_ONLY_SWITCH),
        .listen_only_switch(LISTEN_ONLY_SWITCH), .entry_permit(PANEL_ADDRESS_ENTRY_PERMIT), .show_key(SHOW_BUS_ADDRESS_KEY));
    initial
    begin
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Each channel is released at the edge that takes it; the answer is taken where its valid is seen high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        logic [1:0] r;
        done = 1'b0;
        r = 2'h3;
        @(posedge CLK_SYS);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (!done)
        begin
            @(posedge CLK_SYS);
            if (S_AXI_AWVALID && S_AXI_AWREADY)
                S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
                S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID)
            begin
                done = 1'b1;
                r = S_AXI_BRESP;
            end
        end
        S_AXI_BREADY <= 1'b0;
        chk(32'(r), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic done;
        logic [1:0] r;
        done = 1'b0;
        r = 2'h3;
        d = 32'h0;
        @(posedge CLK_SYS);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        while (!done)
        begin
            @(posedge CLK_SYS);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
                S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID)
            begin
                done = 1'b1;
                d = S_AXI_RDATA;
                r = S_AXI_RRESP;
            end
        end
        S_AXI_RREADY <= 1'b0;
        chk(32'(r), 32'(er));
    endtask
    task automatic settle();
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask
    task automatic put(input logic [8:0] v);
        @(posedge CLK_SYS);
        sw <= v;
        settle();
    endtask
    // Key in, then store, then local; the keep-panel bit rides along
    task automatic pe(input logic [4:0] v, input int x);
        wr(GAS_OFF_PANEL, 32'(v), GAS_RESP_OKAY);
        wr(GAS_OFF_CTRL, 32'h3, GAS_RESP_OKAY);
        wr(GAS_OFF_CTRL, 32'h5, GAS_RESP_OKAY);
        settle();
        chk(32'(BUS_ADDRESS), 32'(x));
    endtask
    always @(posedge CLK_SYS)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge CLK_SYS);
        SRST <= 1'b0;
        settle();
        chk({TALK_CHAR, LISTEN_CHAR, 11'h000, BUS_ADDRESS}, 32'h53330013);
        for (i = 0; i < 32; i++)
        begin
            put(9'(i));
            e = (i == 31) ? 19 : i;
            chk(32'(BUS_ADDRESS), 32'(e));
            chk({LISTEN_CHAR, TALK_CHAR}, 32'(((e + 32) << 8) + e + 64));
            rd(GAS_OFF_CHARS, rdv, GAS_RESP_OKAY);
            chk(rdv, 32'(((e + 32) << 8) + e + 64));
        end
        for (i = 0; i < 4; i++)
        begin
            put({2'b10, 2'(i), 5'h07});
            e = i[0] ? 50 : (i[1] ? 40 : 7);
            chk({TALK_ONLY, LISTEN_ONLY}, {i[0], i == 2});
            chk(32'(NUMERIC_READOUT), 32'((e / 10) * 16 + e % 10));
            rd(GAS_OFF_STATUS, rdv, GAS_RESP_OKAY);
            chk(rdv & 32'h3F, 32'(e));
        end
        put(9'h007);
        chk({READOUT_ACTIVE, NUMERIC_READOUT}, 32'h0);
        put(9'h085);
        pe(5'h09, 9);
        chk(32'(TALK_CHAR), 32'h49);
        rd(GAS_OFF_STATUS, rdv, GAS_RESP_OKAY);
        chk(32'(rdv[10]), 32'h1);
        // Without byte lane 0 the revert request must be ignored
        @(posedge CLK_SYS);
        S_AXI_WSTRB <= 4'hE;
        wr(GAS_OFF_CTRL, 32'h0, GAS_RESP_OKAY);
        S_AXI_WSTRB <= 4'hF;
        settle();
        chk(32'(BUS_ADDRESS), 32'h9);
        wr(GAS_OFF_CTRL, 32'h0, GAS_RESP_OKAY);
        settle();
        chk(32'(BUS_ADDRESS), 32'h5);
        // Local before store abandons the keyed value
        wr(GAS_OFF_PANEL, 32'h0A, GAS_RESP_OKAY);
        wr(GAS_OFF_CTRL, 32'h5, GAS_RESP_OKAY);
        wr(GAS_OFF_CTRL, 32'h3, GAS_RESP_OKAY);
        rd(GAS_OFF_STATUS, rdv, GAS_RESP_OKAY);
        chk(32'(rdv[13:10]), 32'h2);
        chk(32'(BUS_ADDRESS), 32'h5);
        pe(5'h1F, 5);
        put(9'h005);
        pe(5'h0C, 5);
        rd(GAS_OFF_STATUS, rdv, GAS_RESP_OKAY);
        chk(32'(rdv[12]), 32'h1);
        wr(GAS_OFF_STATUS, 32'h1, GAS_RESP_SLVERR);
        rd(8'h10, rdv, GAS_RESP_SLVERR);
        chk(rdv, 32'h0);
        end_of_test();
    end
endmodule
